// File: design/lioprt_ports.sv
// Latched general-purpose ports two to five with separate latch and pin reads
`timescale 1ns/1ps
`include "lioprt_map.svh"
// Contract
// - Low-frequency port has three latched I/O pins
// - Reset loads three-pin latch with ones
// - Dual-clock mode gives upper pins to crystal
// - Driven stop-release pin falling edge sets interrupt
// - Three-pin reads give latch or pin levels
// - Stop mode floats stop-release pin always
// - Heavy port A eight pins, reset ones
// - Reset: serial latch ones, driver type zero
// - Driver type zero open-drain, one push-pull
// - Serial port has separate latch/pin reads
// - Heavy port B five pins, reset ones
// - Heavy B reads define only bits four-zero
// - Pins sampled before read, latch drives after write
module lioprt_ports (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  dual_clock_mode,
  input  wire logic                  stop_mode,
  input  wire logic                  global_output_enable,
  input  wire logic                  lf_wr,
  input  wire logic                  ha_wr,
  input  wire logic                  sp_wr,
  input  wire logic                  sp_type_wr,
  input  wire logic                  hb_wr,
  input  wire lioprt_pkg::lioprt_byte_t wr_data,
  input  wire logic                  lf_rd,
  input  wire logic                  ha_rd,
  input  wire logic                  sp_rd,
  input  wire logic                  hb_rd,
  input  wire lioprt_pkg::lioprt_rsel_t rd_sel,
  input  wire logic [2:0]            lf_pin_in,
  input  wire logic [7:0]            ha_pin_in,
  input  wire logic [7:0]            sp_pin_in,
  input  wire logic [4:0]            hb_pin_in,
  output logic [2:0]                 lf_pin_out,
  output logic [2:0]                 lf_pin_oe,
  output logic [7:0]                 ha_pin_out,
  output logic [7:0]                 ha_pin_oe,
  output logic [7:0]                 sp_pin_out,
  output logic [7:0]                 sp_pin_oe,
  output logic [4:0]                 hb_pin_out,
  output logic [4:0]                 hb_pin_oe,
  output logic                       stop_release_irq,
  output lioprt_pkg::lioprt_byte_t   rd_data,
  output logic                       rd_valid
);
  import lioprt_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [23:0] pin_meta_q;
  logic [23:0] pin_sync_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_q <= 24'h000000;
      pin_sync_q <= 24'h000000;
    end else begin
      pin_meta_q <= {hb_pin_in, sp_pin_in, ha_pin_in, lf_pin_in};
      pin_sync_q <= pin_meta_q;
    end
  end
  logic [2:0] lf_pin_s;
  logic [7:0] ha_pin_s;
  logic [7:0] sp_pin_s;
  logic [4:0] hb_pin_s;
  assign lf_pin_s = pin_sync_q[2:0];
  assign ha_pin_s = pin_sync_q[10:3];
  assign sp_pin_s = pin_sync_q[18:11];
  assign hb_pin_s = pin_sync_q[23:19];

  // ----------------------------------------------------------------
  // Output latches
  // ----------------------------------------------------------------
  logic [2:0] lf_latch_q;
  logic [7:0] ha_latch_q;
  logic [7:0] sp_latch_q;
  logic [7:0] sp_type_q;
  logic [4:0] hb_latch_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lf_latch_q <= `LIOPRT_LF_RST;
    end else if (lf_wr) begin
      lf_latch_q <= wr_data[2:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ha_latch_q <= `LIOPRT_HA_RST;
    end else if (ha_wr) begin
      ha_latch_q <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp_latch_q <= `LIOPRT_SP_RST;
      sp_type_q  <= `LIOPRT_SP_TYPE_RST;
    end else begin
      if (sp_wr) begin
        sp_latch_q <= wr_data;
      end
      if (sp_type_wr) begin
        sp_type_q <= wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hb_latch_q <= `LIOPRT_HB_RST;
    end else if (hb_wr) begin
      hb_latch_q <= wr_data[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, registered so pins change the cycle after a write
  // ----------------------------------------------------------------
  // Latches hold ones as pulled-high inputs: a one releases the pin, except on push-pull serial pins, where it drives high.
  logic [2:0] lf_oe_d;
  always_comb begin
    lf_oe_d = ~lf_latch_q & {3{global_output_enable}};
    if (dual_clock_mode) begin
      lf_oe_d[`LIOPRT_CRYSTAL_IN_BIT]  = 1'b0;
      lf_oe_d[`LIOPRT_CRYSTAL_OUT_BIT] = 1'b0;
    end
    // Stop pin floats regardless of the global enable
    if (stop_mode) begin
      lf_oe_d[`LIOPRT_STOP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lf_pin_out <= 3'h0;
      lf_pin_oe  <= 3'h0;
      ha_pin_out <= 8'h00;
      ha_pin_oe  <= 8'h00;
      sp_pin_out <= 8'h00;
      sp_pin_oe  <= 8'h00;
      hb_pin_out <= 5'h00;
      hb_pin_oe  <= 5'h00;
    end else begin
      lf_pin_out <= lf_latch_q & {3{~dual_clock_mode}} | (lf_latch_q & 3'h1);
      lf_pin_oe  <= lf_oe_d;
      ha_pin_out <= ha_latch_q & {8{global_output_enable}};
      ha_pin_oe  <= ~ha_latch_q & {8{global_output_enable}};
      sp_pin_out <= sp_latch_q & sp_type_q & {8{global_output_enable}};
      // Open-drain drives only lows; push-pull drives both levels
      sp_pin_oe  <= (sp_type_q | ~sp_latch_q) & {8{global_output_enable}};
      hb_pin_out <= hb_latch_q & {5{global_output_enable}};
      hb_pin_oe  <= ~hb_latch_q & {5{global_output_enable}};
    end
  end

  // ----------------------------------------------------------------
  // Stop-release interrupt pulse
  // ----------------------------------------------------------------
  // The edge is taken from the synced pin, so a driven output pulse
  // that falls on the wire raises the one-cycle interrupt just as an external one.
  logic stop_pin_prev_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Matches the cleared synchroniser, so reset release gives no false edge
      stop_pin_prev_q  <= 1'b0;
      stop_release_irq <= 1'b0;
    end else begin
      stop_pin_prev_q  <= lf_pin_s[`LIOPRT_STOP_BIT];
      stop_release_irq <= stop_pin_prev_q & ~lf_pin_s[`LIOPRT_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  function automatic lioprt_byte_t lioprt_pick(input lioprt_rsel_t sel,
                                               input lioprt_byte_t latch,
                                               input lioprt_byte_t pins);
    case (sel)
      LIOPRT_SEL_LATCH: lioprt_pick = latch;
      LIOPRT_SEL_PIN:   lioprt_pick = pins;
      default:          lioprt_pick = 8'h00;
    endcase
  endfunction : lioprt_pick

  lioprt_byte_t rd_data_d;
  always_comb begin
    rd_data_d = 8'h00;
    if (lf_rd) begin
      rd_data_d = lioprt_pick(rd_sel, {5'h00, lf_latch_q}, {5'h00, lf_pin_s});
    end else if (ha_rd) begin
      rd_data_d = lioprt_pick(rd_sel, ha_latch_q, ha_pin_s);
    end else if (sp_rd) begin
      rd_data_d = lioprt_pick(rd_sel, sp_latch_q, sp_pin_s);
    end else if (hb_rd) begin
      rd_data_d = lioprt_pick(rd_sel, {3'h0, hb_latch_q}, {3'h0, hb_pin_s});
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= rd_data_d;
      rd_valid <= lf_rd | ha_rd | sp_rd | hb_rd;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_stop_float;
    @(posedge core_clk) disable iff (sys_rst)
      stop_mode |=> !lf_pin_oe[0];
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("stop pin driven in stop");

  property p_xtal_free;
    @(posedge core_clk) disable iff (sys_rst)
      dual_clock_mode |=> (lf_pin_oe[2:1] == 2'b00);
  endproperty
  a_xtal_free: assert property (p_xtal_free) else $error("crystal pins driven");

  property p_od_high;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> ((sp_pin_oe & sp_pin_out & ~$past(sp_type_q)) == 8'h00);
  endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain drove high");

  property p_lf_upper_zero;
    @(posedge core_clk) disable iff (sys_rst)
      lf_rd |=> rd_valid && (rd_data[7:3] == 5'h00);
  endproperty
  a_lf_upper_zero: assert property (p_lf_upper_zero) else $error("lf upper bits set");

  property p_hb_upper_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (hb_rd && !lf_rd && !ha_rd && !sp_rd) |=> (rd_data[7:5] == 3'h0);
  endproperty
  a_hb_upper_zero: assert property (p_hb_upper_zero) else $error("hb upper bits set");

  property p_sp_latch_rd;
    @(posedge core_clk) disable iff (sys_rst)
      (sp_rd && !lf_rd && !ha_rd && rd_sel == LIOPRT_SEL_LATCH) |=>
        (rd_data == $past(sp_latch_q));
  endproperty
  a_sp_latch_rd: assert property (p_sp_latch_rd) else $error("serial latch read wrong");

  property p_ha_write;
    @(posedge core_clk) disable iff (sys_rst)
      (ha_wr && global_output_enable) |=> ##1 (ha_pin_oe == ~$past(wr_data, 2));
  endproperty
  a_ha_write: assert property (p_ha_write) else $error("heavy A pin not updated");

  property p_irq_fall;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(lf_pin_s[0]) |=> stop_release_irq;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("stop edge missed");
endmodule : lioprt_ports

// File: design/lioprt_map.svh
// Constants for the latched I/O ports two to five
`ifndef LIOPRT_MAP_SVH
`define LIOPRT_MAP_SVH
`define LIOPRT_LF_W        3
`define LIOPRT_HA_W        8
`define LIOPRT_SP_W        8
`define LIOPRT_HB_W        5
`define LIOPRT_LF_RST      3'h7
`define LIOPRT_HA_RST      8'hff
`define LIOPRT_SP_RST      8'hff
`define LIOPRT_SP_TYPE_RST 8'h00
`define LIOPRT_HB_RST      5'h1f
`define LIOPRT_STOP_BIT    0
`define LIOPRT_CRYSTAL_IN_BIT  1
`define LIOPRT_CRYSTAL_OUT_BIT 2
`endif

// File: design/lioprt_pkg.sv
// Types for the latched I/O ports two to five
package lioprt_pkg;
  typedef logic [7:0] lioprt_byte_t;
  typedef enum logic [1:0] {
    LIOPRT_SEL_LATCH = 2'b01,
    LIOPRT_SEL_PIN   = 2'b10
  } lioprt_rsel_t;
endpackage : lioprt_pkg

// File: verification/lioprt_board.sv
// Board model for one port: pulled-up wires with optional external pull-downs
`timescale 1ns/1ps
module lioprt_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext_low,
  output logic      [W-1:0] pin_lvl
);
  // A released wire floats up to one; an external pull-down wins any contest
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_lvl[i] = !(ext_low[i] || (pin_oe[i] && !pin_out[i]));
    end
  end
endmodule : lioprt_board

// File: verification/lioprt_ports_bench.sv
// Self-checking bench for the latched I/O ports on pulled-up board wires
`timescale 1ns/1ps
module lioprt_ports_bench;
  import lioprt_pkg::*;
  logic         core_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         dual_clock_mode = 1'b0;
  logic         stop_mode = 1'b0;
  logic         global_output_enable = 1'b1;
  logic [4:0]   wr_s = 5'h00;
  logic [3:0]   rd_s = 4'h0;
  lioprt_byte_t wr_data = 8'h00;
  lioprt_rsel_t rd_sel = LIOPRT_SEL_LATCH;
  logic [2:0]   lf_pin_in, lf_pin_out, lf_pin_oe, lf_low = 3'h0;
  logic [7:0]   ha_pin_in, ha_pin_out, ha_pin_oe, ha_low = 8'h00;
  logic [7:0]   sp_pin_in, sp_pin_out, sp_pin_oe, sp_low = 8'h00;
  logic [4:0]   hb_pin_in, hb_pin_out, hb_pin_oe, hb_low = 5'h00;
  logic         stop_release_irq, rd_valid;
  lioprt_byte_t rd_data;
  int           err_count = 0, checked = 0, cycles = 0, irq_count = 0;

  always #25 core_clk = ~core_clk;

  lioprt_ports i_dut (
    .core_clk, .sys_rst, .dual_clock_mode, .stop_mode, .global_output_enable,
    .lf_wr(wr_s[0]), .ha_wr(wr_s[1]), .sp_wr(wr_s[2]), .sp_type_wr(wr_s[3]), .hb_wr(wr_s[4]),
    .wr_data, .lf_rd(rd_s[0]), .ha_rd(rd_s[1]), .sp_rd(rd_s[2]), .hb_rd(rd_s[3]), .rd_sel,
    .lf_pin_in, .ha_pin_in, .sp_pin_in, .hb_pin_in, .lf_pin_out, .lf_pin_oe, .ha_pin_out,
    .ha_pin_oe, .sp_pin_out, .sp_pin_oe, .hb_pin_out, .hb_pin_oe, .stop_release_irq,
    .rd_data, .rd_valid
  );
  lioprt_board #(.W(3)) i_lf (.pin_out(lf_pin_out), .pin_oe(lf_pin_oe), .ext_low(lf_low),
                              .pin_lvl(lf_pin_in));
  lioprt_board #(.W(8)) i_ha (.pin_out(ha_pin_out), .pin_oe(ha_pin_oe), .ext_low(ha_low),
                              .pin_lvl(ha_pin_in));
  lioprt_board #(.W(8)) i_sp (.pin_out(sp_pin_out), .pin_oe(sp_pin_oe), .ext_low(sp_low),
                              .pin_lvl(sp_pin_in));
  lioprt_board #(.W(5)) i_hb (.pin_out(hb_pin_out), .pin_oe(hb_pin_oe), .ext_low(hb_low),
                              .pin_lvl(hb_pin_in));

  // ----------------------------
  // Access tasks and checking
  // ----------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (stop_release_irq === 1'b1) irq_count <= irq_count + 1;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input lioprt_byte_t got, input lioprt_byte_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Index: 0 three-pin, 1 heavy A, 2 serial, 3 serial driver type, 4 heavy B
  task automatic wr(input int idx, input lioprt_byte_t d);
    @(posedge core_clk);
    wr_s <= 5'h01 << idx;
    wr_data <= d;
    @(posedge core_clk);
    wr_s <= 5'h00;
    tick(1);
  endtask : wr

  // Index: 0 three-pin, 1 heavy A, 2 serial, 3 heavy B
  task automatic rdc(input int idx, input lioprt_rsel_t s, input lioprt_byte_t exp);
    @(posedge core_clk);
    rd_s <= 4'h1 << idx;
    rd_sel <= s;
    @(posedge core_clk);
    rd_s <= 4'h0;
    #1;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask : rdc

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ----------------------------
  // Test sequence
  // ----------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(0, LIOPRT_SEL_LATCH, 8'h07);
    rdc(1, LIOPRT_SEL_LATCH, 8'hff);
    rdc(2, LIOPRT_SEL_LATCH, 8'hff);
    rdc(3, LIOPRT_SEL_LATCH, 8'h1f);
    chk(sp_pin_oe, 8'h00);
    rdc(2, LIOPRT_SEL_PIN, 8'hff);
    wr(0, 8'hfa);
    chk({5'h00, lf_pin_oe}, 8'h05);
    chk({5'h00, lf_pin_out}, 8'h02);
    rdc(0, LIOPRT_SEL_LATCH, 8'h02);
    tick(5);
    chk(lioprt_byte_t'(irq_count), 8'h01);
    rdc(0, LIOPRT_SEL_PIN, 8'h02);
    dual_clock_mode <= 1'b1;
    tick(2);
    chk({5'h00, lf_pin_oe}, 8'h01);
    dual_clock_mode <= 1'b0;
    stop_mode <= 1'b1;
    tick(2);
    chk({5'h00, lf_pin_oe}, 8'h04);
    tick(4);
    stop_mode <= 1'b0;
    tick(6);
    chk(lioprt_byte_t'(irq_count), 8'h02);
    wr(0, 8'h07);
    tick(4);
    lf_low <= 3'h1;
    tick(6);
    chk(lioprt_byte_t'(irq_count), 8'h03);
    wr(1, 8'h0f);
    chk(ha_pin_oe, 8'hf0);
    chk(ha_pin_out, 8'h0f);
    ha_low <= 8'h0c;
    tick(3);
    rdc(1, LIOPRT_SEL_PIN, 8'h03);
    wr(2, 8'h0f);
    chk(sp_pin_oe, 8'hf0);
    chk(sp_pin_out, 8'h00);
    wr(3, 8'hff);
    chk(sp_pin_oe, 8'hff);
    chk(sp_pin_out, 8'h0f);
    tick(3);
    rdc(2, LIOPRT_SEL_PIN, 8'h0f);
    wr(2, 8'hff);
    wr(3, 8'h00);
    sp_low <= 8'h81;
    tick(3);
    rdc(2, LIOPRT_SEL_PIN, 8'h7e);
    wr(4, 8'hea);
    rdc(3, LIOPRT_SEL_LATCH, 8'h0a);
    chk({3'h0, hb_pin_oe}, 8'h15);
    chk({3'h0, hb_pin_out}, 8'h0a);
    tick(3);
    rdc(3, LIOPRT_SEL_PIN, 8'h0a);
    global_output_enable <= 1'b0;
    tick(2);
    chk(ha_pin_oe, 8'h00);
    chk({3'h0, hb_pin_oe}, 8'h00);
    global_output_enable <= 1'b1;
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    rdc(1, LIOPRT_SEL_LATCH, 8'hff);
    end_sim();
  end
endmodule : lioprt_ports_bench
